// File: include/cmah_pkg.sv
package cmah_pkg;

    // Clocking
    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned MAX_CLK_HZ = 16_000_000;

    // Address handling
    localparam int          PC_W       = 24;
    localparam int          NORM_EA_W  = 16;
    localparam int          ADV_EA_W   = 24;
    localparam logic [31:0] VEC_BASE   = 32'h0000_0000;
    localparam logic [31:0] MIND_LAST  = 32'h0000_00FF;
    localparam logic [2:0]  WORD_STEP  = 3'h2;
    localparam logic [2:0]  LONG_STEP  = 3'h4;

    // Multiply state counts
    localparam logic [4:0]  UMUL_B_ST  = 5'd12;
    localparam logic [4:0]  UMUL_W_ST  = 5'd20;
    localparam logic [4:0]  SMUL_B_ST  = 5'd13;
    localparam logic [4:0]  SMUL_W_ST  = 5'd21;

    // Stack push slots
    localparam logic [1:0]  PUSH_EXT   = 2'h0;
    localparam logic [1:0]  PUSH_COND  = 2'h1;
    localparam logic [1:0]  PUSH_PC    = 2'h2;

    // Reset values
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    typedef enum logic [3:0] {
        OP_EA     = 4'h0,
        OP_FETCH  = 4'h1,
        OP_INC    = 4'h2,
        OP_DEC    = 4'h3,
        OP_VEC    = 4'h4,
        OP_MIND   = 4'h5,
        OP_CALL   = 4'h6,
        OP_EXC    = 4'h7,
        OP_UMUL_B = 4'h8,
        OP_UMUL_W = 4'h9,
        OP_SMUL_B = 4'hA,
        OP_SMUL_W = 4'hB,
        OP_SLEEP  = 4'hC,
        OP_MAC    = 4'hD
    } cmah_op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_READ  = 3'h1,
        ST_PUSH  = 3'h3,
        ST_MUL   = 3'h2,
        ST_SLEEP = 3'h6
    } cmah_state_e;

endpackage : cmah_pkg

// File: core/cmah_core.sv
// Operation
// - Mode comes from the mode pins
// - Normal mode keeps low 16 address bits
// - Increment/decrement carry reaches extended half
// - Normal vectors are 16-bit from zero
// - Memory-indirect uses 8-bit absolute operand address
// - Normal indirect operands within first 256 bytes
// - Calls push PC, in advanced mode with condition code; exceptions add status registers
// - Advanced mode reaches linear 16-Mbyte space
// - Advanced vectors 32-bit, low 24 used
// - Advanced indirect operand longword, top byte zero
// - Extended halves serve as 32-bit upper halves
// - Multiply takes 12, 20, 13, 21 states
// - Common operations finish in one state
// - No multiply-accumulate register or instructions
// - Sleep enters the power-down state
// - PC 24 bits, fetch ignores bit 0
module cmah_core
    import cmah_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Mode strap, high selects advanced mode
    input  wire logic        modeAdv,
    // Request
    input  wire logic        reqValid,
    input  wire cmah_op_e    reqOp,
    input  wire logic [31:0] reqA,
    input  wire logic [31:0] reqB,
    input  wire logic [31:0] spIn,
    input  wire logic [23:0] pcIn,
    input  wire logic [7:0]  condCodeIn,
    input  wire logic [7:0]  extCtrlIn,
    input  wire logic        extCtrlValid,
    input  wire logic        wakeIn,
    output logic             reqReady,
    // Answer
    output logic             doneOut,
    output logic             illegalOut,
    output logic [31:0]      resultOut,
    output logic [31:0]      addrOut,
    output logic [31:0]      spOut,
    output logic             advModeOut,
    output logic             sleepOut,
    // Memory
    output logic [31:0]      memAddr,
    output logic             memRd,
    output logic             memWr,
    output logic             memLong,
    output logic [31:0]      memWdata,
    input  wire logic [31:0] memRdata,
    input  wire logic        memReady
);

    function automatic logic [31:0] truncEa(input logic adv, input logic [31:0] ea);
        truncEa = adv ? {8'h00, ea[ADV_EA_W-1:0]}
                      : {16'h0000, ea[NORM_EA_W-1:0]};
    endfunction : truncEa

    function automatic logic [31:0] branchTarget(input logic adv, input logic [31:0] d);
        branchTarget = adv ? {8'h00, d[23:0]}
                           : {16'h0000, d[15:0]};
    endfunction : branchTarget

    function automatic logic [32:0] pushItem(input logic adv, input logic [1:0] k,
                                             input logic [23:0] pc, input logic [7:0] cond,
                                             input logic [7:0] ext);
        case (k)
            PUSH_EXT:  pushItem = {1'b0, 16'h0000, ext, ext};
            PUSH_COND: pushItem = adv ? {1'b1, cond, pc} : {1'b0, 16'h0000, cond, cond};
            default:   pushItem = {1'b0, 16'h0000, pc[15:0]};
        endcase
    endfunction : pushItem

    function automatic logic [31:0] mulResult(input cmah_op_e op, input logic [31:0] a,
                                              input logic [31:0] b);
        logic [15:0] p16;
        logic [31:0] p32;
        p16 = 16'h0000;
        p32 = 32'h0000_0000;
        case (op)
            OP_UMUL_B: begin
                p16 = {8'h00, a[7:0]} * {8'h00, b[7:0]};
                p32 = {16'h0000, p16};
            end
            OP_SMUL_B: begin
                // Low half of sign-extended product is the signed product
                p16 = {{8{a[7]}}, a[7:0]} * {{8{b[7]}}, b[7:0]};
                p32 = {16'h0000, p16};
            end
            OP_UMUL_W: p32 = {16'h0000, a[15:0]} * {16'h0000, b[15:0]};
            default:   p32 = {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]};
        endcase
        mulResult = p32;
    endfunction : mulResult

    function automatic logic [4:0] mulStates(input cmah_op_e op);
        case (op)
            OP_UMUL_B: mulStates = UMUL_B_ST;
            OP_UMUL_W: mulStates = UMUL_W_ST;
            OP_SMUL_B: mulStates = SMUL_B_ST;
            default:   mulStates = SMUL_W_ST;
        endcase
    endfunction : mulStates

    cmah_state_e state_r, state_nxt;
    cmah_op_e    op_r, op_nxt;
    logic        mode_r, mode_nxt;
    logic        done_r, done_nxt;
    logic        illegal_r, illegal_nxt;
    logic [31:0] result_r, result_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [31:0] sp_r, sp_nxt;
    logic [31:0] opA_r, opA_nxt;
    logic [31:0] opB_r, opB_nxt;
    logic [23:0] pc_r, pc_nxt;
    logic [7:0]  condCode_r, condCode_nxt;
    logic [7:0]  extCtrl_r, extCtrl_nxt;
    logic [1:0]  idx_r, idx_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [31:0] memAddr_r, memAddr_nxt;
    logic [31:0] memWdata_r, memWdata_nxt;
    logic        memRd_r, memRd_nxt;
    logic        memWr_r, memWr_nxt;
    logic        memLong_r, memLong_nxt;

    always_comb begin
        logic        doPush;
        logic [1:0]  pushLast;
        logic [32:0] item;
        logic [31:0] tmp;
        doPush       = 1'b0;
        item         = 33'h0_0000_0000;
        tmp          = 32'h0000_0000;
        pushLast     = mode_r ? PUSH_COND : PUSH_PC;
        state_nxt    = state_r;
        op_nxt       = op_r;
        mode_nxt     = mode_r;
        done_nxt     = 1'b0;
        illegal_nxt  = 1'b0;
        result_nxt   = result_r;
        addr_nxt     = addr_r;
        sp_nxt       = sp_r;
        opA_nxt      = opA_r;
        opB_nxt      = opB_r;
        pc_nxt       = pc_r;
        condCode_nxt = condCode_r;
        extCtrl_nxt  = extCtrl_r;
        idx_nxt      = idx_r;
        cnt_nxt      = cnt_r;
        memAddr_nxt  = memAddr_r;
        memWdata_nxt = memWdata_r;
        memRd_nxt    = memRd_r;
        memWr_nxt    = memWr_r;
        memLong_nxt  = memLong_r;
        if (!nrst) begin
            state_nxt    = ST_IDLE;
            op_nxt       = OP_EA;
            mode_nxt     = modeAdv;
            result_nxt   = RST_WORD;
            addr_nxt     = RST_WORD;
            sp_nxt       = RST_WORD;
            opA_nxt      = RST_WORD;
            opB_nxt      = RST_WORD;
            pc_nxt       = 24'h00_0000;
            condCode_nxt = 8'h00;
            extCtrl_nxt  = 8'h00;
            idx_nxt      = 2'h0;
            cnt_nxt      = 5'h00;
            memAddr_nxt  = RST_WORD;
            memWdata_nxt = RST_WORD;
            memRd_nxt    = 1'b0;
            memWr_nxt    = 1'b0;
            memLong_nxt  = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (reqValid) begin
                        op_nxt = reqOp;
                        case (reqOp)
                            OP_EA: begin
                                addr_nxt = truncEa(mode_r, reqA);
                                done_nxt = 1'b1;
                            end
                            OP_FETCH: begin
                                addr_nxt = truncEa(mode_r, {8'h00, pcIn[PC_W-1:1], 1'b0});
                                done_nxt = 1'b1;
                            end
                            OP_INC: begin
                                result_nxt = reqA + {29'h0, reqB[2:0]};
                                addr_nxt   = truncEa(mode_r, reqA);
                                done_nxt   = 1'b1;
                            end
                            OP_DEC: begin
                                tmp        = reqA - {29'h0, reqB[2:0]};
                                result_nxt = tmp;
                                addr_nxt   = truncEa(mode_r, tmp);
                                done_nxt   = 1'b1;
                            end
                            OP_VEC, OP_MIND: begin
                                if (reqOp == OP_MIND)
                                    tmp = {24'h00_0000, reqA[7:0]} & MIND_LAST;
                                else if (mode_r)
                                    tmp = VEC_BASE | {22'h0, reqA[7:0], 2'b00};
                                else
                                    tmp = VEC_BASE | {23'h0, reqA[7:0], 1'b0};
                                addr_nxt    = tmp;
                                memAddr_nxt = tmp;
                                memLong_nxt = mode_r;
                                memRd_nxt   = 1'b1;
                                state_nxt   = ST_READ;
                            end
                            OP_CALL, OP_EXC: begin
                                pc_nxt       = pcIn;
                                condCode_nxt = condCodeIn;
                                extCtrl_nxt  = extCtrlIn;
                                sp_nxt       = spIn;
                                if (reqOp == OP_CALL)
                                    idx_nxt = pushLast;
                                else
                                    idx_nxt = extCtrlValid ? PUSH_EXT : PUSH_COND;
                                doPush    = 1'b1;
                                state_nxt = ST_PUSH;
                            end
                            OP_UMUL_B, OP_UMUL_W, OP_SMUL_B, OP_SMUL_W: begin
                                opA_nxt   = reqA;
                                opB_nxt   = reqB;
                                cnt_nxt   = mulStates(reqOp) - 5'h01;
                                state_nxt = ST_MUL;
                            end
                            OP_SLEEP: state_nxt = ST_SLEEP;
                            default: begin
                                illegal_nxt = 1'b1;
                                done_nxt    = 1'b1;
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    if (memReady) begin
                        memRd_nxt  = 1'b0;
                        result_nxt = branchTarget(mode_r, memRdata);
                        done_nxt   = 1'b1;
                        state_nxt  = ST_IDLE;
                    end
                end
                ST_PUSH: begin
                    if (memReady) begin
                        if (idx_r == pushLast) begin
                            memWr_nxt = 1'b0;
                            done_nxt  = 1'b1;
                            state_nxt = ST_IDLE;
                        end else begin
                            idx_nxt = idx_r + 2'h1;
                            doPush  = 1'b1;
                        end
                    end
                end
                ST_MUL: begin
                    if (cnt_r == 5'h01) begin
                        result_nxt = mulResult(op_r, opA_r, opB_r);
                        done_nxt   = 1'b1;
                        state_nxt  = ST_IDLE;
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
                ST_SLEEP: begin
                    if (wakeIn) begin
                        done_nxt  = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
            if (doPush) begin
                item         = pushItem(mode_r, idx_nxt, pc_nxt, condCode_nxt, extCtrl_nxt);
                sp_nxt       = sp_nxt - {29'h0, item[32] ? LONG_STEP : WORD_STEP};
                memAddr_nxt  = truncEa(mode_r, sp_nxt);
                memWdata_nxt = item[31:0];
                memLong_nxt  = item[32];
                memWr_nxt    = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        state_r    <= state_nxt;
        op_r       <= op_nxt;
        mode_r     <= mode_nxt;
        done_r     <= done_nxt;
        illegal_r  <= illegal_nxt;
        result_r   <= result_nxt;
        addr_r     <= addr_nxt;
        sp_r       <= sp_nxt;
        opA_r      <= opA_nxt;
        opB_r      <= opB_nxt;
        pc_r       <= pc_nxt;
        condCode_r <= condCode_nxt;
        extCtrl_r  <= extCtrl_nxt;
        idx_r      <= idx_nxt;
        cnt_r      <= cnt_nxt;
        memAddr_r  <= memAddr_nxt;
        memWdata_r <= memWdata_nxt;
        memRd_r    <= memRd_nxt;
        memWr_r    <= memWr_nxt;
        memLong_r  <= memLong_nxt;
    end

    assign reqReady   = (state_r == ST_IDLE);
    assign doneOut    = done_r;
    assign illegalOut = illegal_r;
    assign resultOut  = result_r;
    assign addrOut    = addr_r;
    assign spOut      = sp_r;
    assign advModeOut = mode_r;
    assign sleepOut   = (state_r == ST_SLEEP);
    assign memAddr    = memAddr_r;
    assign memWdata   = memWdata_r;
    assign memRd      = memRd_r;
    assign memWr      = memWr_r;
    assign memLong    = memLong_r;

endmodule : cmah_core

// File: sim/cmah_sva.sv
module cmah_sva
    import cmah_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // Request
    input wire logic        reqValid,
    input wire cmah_op_e    reqOp,
    input wire logic [31:0] reqA,
    input wire logic        wakeIn,
    input wire logic        reqReady,
    // Answer
    input wire logic        doneOut,
    input wire logic        illegalOut,
    input wire logic [31:0] addrOut,
    input wire logic        advModeOut,
    input wire logic        sleepOut,
    // Memory
    input wire logic [31:0] memAddr,
    input wire logic        memRd,
    input wire logic        memLong
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic       tk;
    logic       mulPend_r, mulPend_nxt;
    logic [4:0] mulCnt_r, mulCnt_nxt, mulExp_r, mulExp_nxt;

    assign tk = reqValid && reqReady;

    // States spent in a multiply
    always_comb begin
        mulPend_nxt = mulPend_r && !doneOut;
        mulCnt_nxt  = mulCnt_r + 5'h01;
        mulExp_nxt  = mulExp_r;
        if (tk && reqOp inside {OP_UMUL_B, OP_UMUL_W, OP_SMUL_B, OP_SMUL_W}) begin
            mulPend_nxt = 1'b1;
            mulCnt_nxt  = 5'h01;
            case (reqOp)
                OP_UMUL_B: mulExp_nxt = 5'h0C;
                OP_UMUL_W: mulExp_nxt = 5'h14;
                OP_SMUL_B: mulExp_nxt = 5'h0D;
                default:   mulExp_nxt = 5'h15;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        mulPend_r <= nrst && mulPend_nxt;
        mulCnt_r  <= mulCnt_nxt;
        mulExp_r  <= mulExp_nxt;
    end

    sequence sleepTake;
        tk && reqOp == OP_SLEEP;
    endsequence

    sequence wakeUp;
        sleepOut && wakeIn ##1 !sleepOut && doneOut;
    endsequence

    ea_trunc_a: assert property (
        tk && reqOp == OP_EA |=> doneOut
            && addrOut == ((advModeOut ? 32'h00FF_FFFF : 32'h0000_FFFF) & $past(reqA)))
        else $error("effective address not cut to mode width");
    vec_addr_a: assert property (
        tk && reqOp == OP_VEC |=> memRd && memLong == advModeOut
            && memAddr == ((32'h0000_00FF & $past(reqA)) << (advModeOut ? 2 : 1)))
        else $error("vector entry address or width wrong");
    mind_addr_a: assert property (
        tk && reqOp == OP_MIND |=> memRd && memLong == advModeOut
            && memAddr == (32'h0000_00FF & $past(reqA)))
        else $error("indirect operand address or width wrong");
    mac_refuse_a: assert property (
        tk && reqOp == OP_MAC |=> doneOut && illegalOut)
        else $error("accumulate op not refused");
    fetch_align_a: assert property (
        tk && reqOp == OP_FETCH |=> doneOut && !addrOut[0])
        else $error("fetch address not word aligned");
    mode_hold_a: assert property ($past(nrst) |-> $stable(advModeOut))
        else $error("mode changed outside reset");
    mul_states_a: assert property (
        mulPend_r |-> (doneOut ? mulCnt_r == mulExp_r : mulCnt_r < mulExp_r))
        else $error("multiply state count wrong");
    sleep_enter_a: assert property (sleepTake |=> sleepOut && !doneOut)
        else $error("sleep not entered");
    sleep_wake_a: assert property (sleepOut && wakeIn |-> wakeUp)
        else $error("wake from sleep wrong");
endmodule : cmah_sva

bind cmah_core cmah_sva cmah_sva_inst (
    .core_clk, .nrst, .reqValid, .reqOp, .reqA, .wakeIn, .reqReady, .doneOut, .illegalOut,
    .addrOut, .advModeOut, .sleepOut, .memAddr, .memRd, .memLong
);

// File: sim/cmah_mem_model.sv
module cmah_mem_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Wait states per access
    input  wire logic [1:0]  waitSt,
    // Memory port
    input  wire logic [31:0] memAddr,
    input  wire logic        memRd,
    input  wire logic        memWr,
    output logic      [31:0] memRdata,
    output logic             memReady
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] cnt_r;
    logic [7:0] cyc_r;

    always_ff @(posedge core_clk) begin
        cyc_r <= nrst ? cyc_r + 8'h01 : 8'h5A;
        if (!nrst || memReady || !(memRd || memWr)) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    assign memReady = (memRd || memWr) && cnt_r == waitSt;
    // Junk top byte in table entries, churn between answers
    assign memRdata = memReady ? {8'hC3, memAddr[7:0], ~memAddr[15:0]} : {4{cyc_r}};
endmodule : cmah_mem_model

// File: sim/cpu_mode_address_handling_test.sv
module cpu_mode_address_handling_test
    import cmah_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk = 1'b0, nrst = 1'b0, modeAdv = 1'b0, reqValid = 1'b0;
    logic        extCtrlValid = 1'b0, wakeIn = 1'b0;
    cmah_op_e    reqOp = OP_EA;
    logic [31:0] reqA = 32'h0, reqB = 32'h0, spIn = 32'h0;
    logic [23:0] pcIn = 24'h0;
    logic [7:0]  condCodeIn = 8'h0, extCtrlIn = 8'h0;
    logic [1:0]  waitSt = 2'h0;
    logic        reqReady, doneOut, illegalOut, advModeOut, sleepOut;
    logic        memRd, memWr, memLong, memReady;
    logic [31:0] resultOut, addrOut, spOut, memAddr, memWdata, memRdata;
    logic [33:0] expQ[$];
    logic [63:0] wrQ[$];
    int          num_errors = 0, checks = 0;

    always #50 core_clk = ~core_clk;

    cmah_core cmah_core_inst (.core_clk, .nrst, .modeAdv, .reqValid, .reqOp, .reqA, .reqB,
        .spIn, .pcIn, .condCodeIn, .extCtrlIn, .extCtrlValid, .wakeIn, .reqReady, .doneOut,
        .illegalOut,
        .resultOut, .addrOut, .spOut, .advModeOut, .sleepOut, .memAddr, .memRd, .memWr,
        .memLong, .memWdata, .memRdata, .memReady);

    cmah_mem_model cmah_mem_model_inst (.core_clk, .nrst, .waitSt, .memAddr, .memRd, .memWr,
        .memRdata, .memReady);

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk

    function automatic logic [31:0] rdv(logic [31:0] ad);
        return {8'hC3, ad[7:0], ~ad[15:0]};
    endfunction : rdv

    // Oldest note against each answer and each stack write
    always @(negedge core_clk) begin
        logic [33:0] n;
        logic [63:0] w;
        if (doneOut === 1'b1) begin
            n = expQ.pop_front();
            case (n[33:32])
                2'h0: chk("addrOut", n[31:0], addrOut);
                2'h1: chk("resultOut", n[31:0], resultOut);
                2'h2: chk("spOut", n[31:0], spOut);
                default: chk("illegalOut", n[31:0], {31'h0, illegalOut});
            endcase
        end
        if (memWr === 1'b1 && memReady === 1'b1) begin
            w = wrQ.pop_front();
            chk("memAddr", w[63:32], memAddr);
            chk("memWdata", w[31:0], memLong ? memWdata : {16'h0, memWdata[15:0]});
        end
    end

    task automatic req(cmah_op_e op, logic [31:0] a, logic [31:0] b, logic [1:0] k,
                       logic [31:0] e);
        expQ.push_back({k, e});
        for (int i = 0; i < 300 && reqReady !== 1'b1; i++) @(negedge core_clk);
        reqValid = 1'b1;
        reqOp    = op;
        reqA     = a;
        reqB     = b;
        @(negedge core_clk);
    endtask : req

    task automatic fin(string nm);
        reqValid = 1'b0;
        @(negedge core_clk);
        for (int i = 0; i < 300 && expQ.size() + wrQ.size() > 0; i++) @(negedge core_clk);
        chk("pending notes", 32'h0, expQ.size() + wrQ.size());
        $display("test %s done", nm);
    endtask : fin

    task automatic rst(logic m);
        @(negedge core_clk);
        nrst    = 1'b0;
        modeAdv = m;
        repeat (12) @(negedge core_clk);
        chk("advModeOut", {31'h0, m}, {31'h0, advModeOut});
        nrst    = 1'b1;
        modeAdv = ~m;
    endtask : rst

    task automatic run_mode(logic adv);
        logic [31:0] a;
        logic [31:0] m;
        m      = adv ? 32'h00FF_FFFF : 32'h0000_FFFF;
        waitSt = adv ? 2'h0 : 2'h3;
        a      = $urandom();
        pcIn   = 24'($urandom());
        req(OP_EA, a, 32'h0, 2'h0, a & m);
        req(OP_FETCH, 32'h0, 32'h0, 2'h0, {8'h0, pcIn[23:1], 1'b0} & m);
        req(OP_INC, 32'h1234_FFFF, 32'h2, 2'h1, 32'h1235_0001);
        req(OP_DEC, 32'h0001_0000, 32'h4, 2'h1, 32'h0000_FFFC);
        req(OP_VEC, {24'h0, a[7:0]}, 32'h0, 2'h1,
            rdv(adv ? {22'h0, a[7:0], 2'h0} : {23'h0, a[7:0], 1'b0}) & m);
        req(OP_MIND, a, 32'h0, 2'h1, rdv({24'h0, a[7:0]}) & m);
        fin("address");
        spIn     = 32'h0000_8000;
        condCodeIn   = 8'($urandom());
        extCtrlIn    = 8'($urandom());
        extCtrlValid = 1'b1;
        wrQ.push_back({32'h0000_7FFE, 16'h0, extCtrlIn, extCtrlIn});
        if (adv) wrQ.push_back({32'h0000_7FFA, condCodeIn, pcIn});
        else wrQ.push_back({32'h0000_7FFC, 16'h0, condCodeIn, condCodeIn});
        if (!adv) wrQ.push_back({32'h0000_7FFA, 16'h0, pcIn[15:0]});
        req(OP_EXC, 32'h0, 32'h0, 2'h2, 32'h0000_7FFA);
        fin("exception");
        extCtrlValid = 1'b0;
        if (adv) wrQ.push_back({32'h0000_7FFC, condCodeIn, pcIn});
        else wrQ.push_back({32'h0000_7FFE, 16'h0, condCodeIn, condCodeIn});
        if (!adv) wrQ.push_back({32'h0000_7FFC, 16'h0, pcIn[15:0]});
        req(OP_EXC, 32'h0, 32'h0, 2'h2, 32'h0000_7FFC);
        fin("exception without extended control");
        if (adv) wrQ.push_back({32'h0000_7FFC, condCodeIn, pcIn});
        else wrQ.push_back({32'h0000_7FFE, 16'h0, pcIn[15:0]});
        req(OP_CALL, 32'h0, 32'h0, 2'h2, adv ? 32'h0000_7FFC : 32'h0000_7FFE);
        fin("call");
    endtask : run_mode

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] a;
        logic [31:0] b;
        void'($urandom(98));
        rst(1'b0);
        run_mode(1'b0);
        for (int i = 0; i < 2; i++) begin
            a = $urandom();
            b = $urandom();
            req(OP_UMUL_B, a, b, 2'h1, {16'h0, {8'h0, a[7:0]} * {8'h0, b[7:0]}});
            req(OP_UMUL_W, a, b, 2'h1, {16'h0, a[15:0]} * {16'h0, b[15:0]});
            req(OP_SMUL_B, a, b, 2'h1, {16'h0, {{8{a[7]}}, a[7:0]} * {{8{b[7]}}, b[7:0]}});
            req(OP_SMUL_W, a, b, 2'h1, {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]});
        end
        req(OP_MAC, a, b, 2'h3, 32'h1);
        req(OP_SLEEP, 32'h0, 32'h0, 2'h3, 32'h0);
        reqValid = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("sleepOut", 32'h1, {31'h0, sleepOut});
        chk("reqReady", 32'h0, {31'h0, reqReady});
        wakeIn = 1'b1;
        @(negedge core_clk);
        wakeIn = 1'b0;
        fin("multiply and sleep");
        rst(1'b1);
        run_mode(1'b1);
        chk("advModeOut", 32'h1, {31'h0, advModeOut});
        report_and_stop();
    end
endmodule : cpu_mode_address_handling_test
